//--- alert_status_pkg.sv
/*
 * Constants shared by the limit-status and alert block and its
 * assertion-time counter: register offsets, bit positions, reset values
 * and timer timing.
 * Assumes a 40 MHz core clock and byte-wide register accesses decoded
 * from the serial bus outside this block.
 */
package alert_status_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] LIMIT_STATUS_FIRST_ADDR = 8'h41;
    localparam logic [7:0] LIMIT_STATUS_SECOND_ADDR = 8'h42;
    localparam logic [7:0] ALERT_MASK_FIRST_ADDR = 8'h74;
    localparam logic [7:0] ALERT_MASK_SECOND_ADDR = 8'h75;
    localparam logic [7:0] CONFIG_THIRD_ADDR = 8'h78;
    localparam logic [7:0] ASSERTION_TIME_ADDR = 8'h79;
    localparam logic [7:0] TIMER_LIMIT_ADDR = 8'h7a;
    localparam logic [7:0] CONFIG_FOURTH_ADDR = 8'h7d;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int SR1_SUMMARY_BIT = 7;
    localparam int SR2_TIMER_BIT = 5;
    localparam int MASK1_SECOND_ALL_BIT = 7;
    localparam int MASK1_CORE_BIT = 0;
    localparam int SR1_CORE_BIT = 1;
    localparam int SR1_LOW_SUPPLY_BIT = 0;
    localparam int CFG3_ALERT_BIT = 0;
    localparam int CFG3_THERMAL_EVENT_PIN_EN_BIT = 1;
    localparam int CFG3_BOOST_BIT = 2;

    // Multi-function pin roles
    localparam logic [1:0] PIN_ROLE_TACH = 2'h0;
    localparam logic [1:0] PIN_ROLE_THERMAL_EVENT_PIN = 2'h2;
    localparam logic [1:0] PIN_ROLE_ALERT = 2'h1;
    localparam logic [1:0] PIN_ROLE_GPIO = 2'h3;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [2:0] CFG3_RESET = 3'h0;
    localparam logic [1:0] CFG4_RESET = PIN_ROLE_TACH;
    localparam logic [7:0] TIMER_LIMIT_RESET = 8'h00;
    localparam logic [7:0] TIMER_FULL = 8'hff;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam real CLK_PERIOD_NS = 25.0;
    localparam real TICK_TIME_MS = 22.76;
    localparam int unsigned TICK_CYCLES = int'(TICK_TIME_MS * 1.0e6 / CLK_PERIOD_NS);
    localparam int PRESCALE_W = 20;

endpackage

//--- timer_if.sv
/*
 * Carrier between the status block and its assertion-time counter.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps
interface timer_if;
    logic active;
    logic readClr;
    logic [7:0] value;

    modport timer (input active, input readClr, output value);
    modport ctrl (output active, output readClr, input value);
endinterface

//--- assertion_timer.sv
/*
 * Accumulating thermal-event assertion timer with saturation and
 * clear-on-read.
 * Assumes the active level is already synchronised to clk.
 */
`timescale 1ns/1ps
module assertion_timer
    import alert_status_pkg::*;
#(
    parameter int unsigned TickCycles = TICK_CYCLES
) (
    // Clock and control
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // Timer carrier
    timer_if.timer tif
);
    import alert_status_pkg::*;

    logic [PRESCALE_W-1:0] pre_q;
    logic [7:0] ticks_q;
    logic seen_q;
    logic tickWrap;

    assign tickWrap = (pre_q == PRESCALE_W'(TickCycles - 1));

    // ************************************************************
    // Prescaler, one wrap per counter LSB
    // ************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            pre_q <= '0;
        end else if (ce) begin
            if (tif.readClr) begin
                pre_q <= '0;
            end else if (tif.active) begin
                pre_q <= tickWrap ? '0 : pre_q + 1'b1;
            end
        end
    end

    // ************************************************************
    // Accumulated ticks
    // ************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            ticks_q <= '0;
        end else if (ce) begin
            if (tif.readClr) begin
                ticks_q <= '0;
            end else if (tif.active && tickWrap && ticks_q != TIMER_FULL) begin
                ticks_q <= ticks_q + 1'b1;
            end
        end
    end

    // Assertion seen; a read during an assertion re-arms it at once
    always_ff @(posedge clk) begin
        if (srst) begin
            seen_q <= 1'b0;
        end else if (ce) begin
            if (tif.readClr) begin
                seen_q <= tif.active;
            end else if (tif.active) begin
                seen_q <= 1'b1;
            end
        end
    end

    // Below two ticks only the first-assertion bit shows
    assign tif.value = (ticks_q >= 8'h02) ? ticks_q : {7'h00, seen_q};

endmodule

//--- status_alert_thermal_event_pin_timer.sv
/*
 * Sticky limit-status registers, alert masking, pin-role configuration,
 * fan boost and the thermal-event assertion timer.
 * Assumes limit comparisons arrive as levels on clk, and register
 * accesses arrive as one-cycle read/write strobes from a serial-bus
 * front end. Pin inputs are asynchronous and synchronised here.
 */
`timescale 1ns/1ps
module status_alert_thermal_event_pin_timer
    import alert_status_pkg::*;
#(
    parameter int unsigned TickCycles = alert_status_pkg::TICK_CYCLES
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // Limit comparison results
    input wire logic [4:0] voltOutOfLimit,
    input wire logic [2:0] tempOutOfLimit,
    input wire logic [1:0] diodeFault,
    input wire logic [3:0] fanSlow,
    input wire logic overtempEvent,
    input wire logic vidChangeSel,
    input wire logic [2:0] fanRunning,
    // Asynchronous pins
    input wire logic [5:0] voltageIdCode,
    input wire logic thermalEventMainN,
    input wire logic thermalEventMultiN,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    // Pin drives
    output logic alertSharedOe,
    output logic alertMultiOe,
    output logic alertPinOut,
    output logic fiveVoltInputSel,
    output logic [2:0] fanFullSpeed
);
    import alert_status_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [7:0] pinMeta_q;
    logic [7:0] pinSync_q;
    logic [5:0] vidPrev_q;
    logic [2:0] vidFill_q;
    logic [6:0] sr1_q;
    logic [7:0] sr2_q;
    logic [7:0] mask1_q;
    logic [7:0] mask2_q;
    logic [2:0] cfg3_q;
    logic [1:0] cfg4_q;
    logic [7:0] limit_q;
    logic [7:0] regRdData_q;
    logic alertSharedOe_q;
    logic alertMultiOe_q;
    logic alertPinOut_q;
    logic fiveVoltInputSel_q;
    logic [2:0] fanFullSpeed_q;
    logic [6:0] sr1Src;
    logic [7:0] sr2Src;
    logic rdSr1;
    logic rdSr2;
    logic rdTimer;
    logic thermActive;
    logic vidChanged;
    logic timerOver;
    logic alertReq;
    logic [7:0] sr1View;

    timer_if tmr();

    assertion_timer #(.TickCycles(TickCycles)) timerCore (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .tif(tmr)
    );

    // The strobe is an argument so that continuous assignments see it change
    function automatic logic isRead(input logic rd, input logic [7:0] addr,
                                    input logic [7:0] target);
        return rd && (addr == target);
    endfunction

    // Set wins over the read-clear, so an event in the read cycle survives
    function automatic logic [7:0] stickyNext(input logic [7:0] cur, input logic [7:0] src,
                                              input logic rd);
        return src | (cur & ~{8{rd}});
    endfunction

    assign rdSr1 = isRead(regRd, regAddr, LIMIT_STATUS_FIRST_ADDR);
    assign rdSr2 = isRead(regRd, regAddr, LIMIT_STATUS_SECOND_ADDR);
    assign rdTimer = isRead(regRd, regAddr, ASSERTION_TIME_ADDR);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            pinMeta_q <= 8'hff;
            pinSync_q <= 8'hff;
        end else if (ce) begin
            pinMeta_q <= {thermalEventMultiN, thermalEventMainN, voltageIdCode};
            pinSync_q <= pinMeta_q;
        end
    end

    // Change detection waits until the synchroniser holds real pin values,
    // so the reset fill of the flops never reads as a code change
    always_ff @(posedge clk) begin
        if (srst) begin
            vidPrev_q <= 6'h3f;
            vidFill_q <= 3'h0;
        end else if (ce) begin
            vidPrev_q <= pinSync_q[5:0];
            vidFill_q <= {vidFill_q[1:0], 1'b1};
        end
    end

    assign vidChanged = vidFill_q[2] && (vidPrev_q != pinSync_q[5:0]);

    // Multi-function pin only counts when the thermal function is enabled
    assign thermActive = cfg3_q[CFG3_THERMAL_EVENT_PIN_EN_BIT] &&
        (!pinSync_q[6] || (cfg4_q == PIN_ROLE_THERMAL_EVENT_PIN && !pinSync_q[7]));

    assign tmr.active = thermActive;
    assign tmr.readClr = rdTimer && ce;
    assign timerOver = tmr.value > limit_q;

    // ************************************************************
    // Status sources
    // ************************************************************
    assign sr1Src = {tempOutOfLimit[2], tempOutOfLimit[1], tempOutOfLimit[0],
                     voltOutOfLimit[3], voltOutOfLimit[2], voltOutOfLimit[1],
                     voltOutOfLimit[0]};
    assign sr2Src = {diodeFault[1], diodeFault[0],
                     cfg3_q[CFG3_THERMAL_EVENT_PIN_EN_BIT] ? timerOver : fanSlow[3],
                     fanSlow[2], fanSlow[1], fanSlow[0],
                     overtempEvent,
                     vidChangeSel ? vidChanged : voltOutOfLimit[4]};

    always_ff @(posedge clk) begin
        if (srst) begin
            sr1_q <= '0;
        end else if (ce) begin
            sr1_q <= 7'(stickyNext({1'b0, sr1_q}, {1'b0, sr1Src}, rdSr1));
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            sr2_q <= '0;
        end else if (ce) begin
            sr2_q <= stickyNext(sr2_q, sr2Src, rdSr2);
        end
    end

    assign sr1View = {|sr2_q, sr1_q};

    // ************************************************************
    // Alert decision
    // ************************************************************
    // The low-supply bit has no mask position and always reaches the alert
    assign alertReq = (|(sr1_q[6:2] & ~mask1_q[6:2]))
        || (sr1_q[SR1_CORE_BIT] && !mask1_q[MASK1_CORE_BIT])
        || sr1_q[SR1_LOW_SUPPLY_BIT]
        || ((|(sr2_q & ~mask2_q)) && !mask1_q[MASK1_SECOND_ALL_BIT]);

    always_ff @(posedge clk) begin
        if (srst) begin
            alertSharedOe_q <= 1'b0;
            alertMultiOe_q <= 1'b0;
            alertPinOut_q <= 1'b0;
        end else if (ce) begin
            alertSharedOe_q <= cfg3_q[CFG3_ALERT_BIT] && alertReq;
            alertMultiOe_q <= (cfg4_q == PIN_ROLE_ALERT) && alertReq;
            alertPinOut_q <= 1'b0;
        end
    end

    // ************************************************************
    // Fan boost and pin roles
    // ************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            fanFullSpeed_q <= '0;
            fiveVoltInputSel_q <= 1'b1;
        end else if (ce) begin
            fanFullSpeed_q <= {3{cfg3_q[CFG3_BOOST_BIT] && thermActive}} & fanRunning;
            fiveVoltInputSel_q <= !cfg3_q[CFG3_THERMAL_EVENT_PIN_EN_BIT];
        end
    end

    // ************************************************************
    // Register writes
    // ************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            mask1_q <= MASK_RESET;
            mask2_q <= MASK_RESET;
            cfg3_q <= CFG3_RESET;
            cfg4_q <= CFG4_RESET;
            limit_q <= TIMER_LIMIT_RESET;
        end else if (ce && regWr) begin
            unique case (regAddr)
                ALERT_MASK_FIRST_ADDR: mask1_q <= regWrData;
                ALERT_MASK_SECOND_ADDR: mask2_q <= regWrData;
                CONFIG_THIRD_ADDR: cfg3_q <= regWrData[2:0];
                CONFIG_FOURTH_ADDR: cfg4_q <= regWrData[1:0];
                TIMER_LIMIT_ADDR: limit_q <= regWrData;
                default: ;
            endcase
        end
    end

    // ************************************************************
    // Register reads
    // ************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            regRdData_q <= '0;
        end else if (ce && regRd) begin
            unique case (regAddr)
                LIMIT_STATUS_FIRST_ADDR: regRdData_q <= sr1View;
                LIMIT_STATUS_SECOND_ADDR: regRdData_q <= sr2_q;
                ALERT_MASK_FIRST_ADDR: regRdData_q <= mask1_q;
                ALERT_MASK_SECOND_ADDR: regRdData_q <= mask2_q;
                CONFIG_THIRD_ADDR: regRdData_q <= {5'h00, cfg3_q};
                ASSERTION_TIME_ADDR: regRdData_q <= tmr.value;
                TIMER_LIMIT_ADDR: regRdData_q <= limit_q;
                CONFIG_FOURTH_ADDR: regRdData_q <= {6'h00, cfg4_q};
                default: regRdData_q <= 8'h00;
            endcase
        end
    end

    assign regRdData = regRdData_q;
    assign alertSharedOe = alertSharedOe_q;
    assign alertMultiOe = alertMultiOe_q;
    assign alertPinOut = alertPinOut_q;
    assign fiveVoltInputSel = fiveVoltInputSel_q;
    assign fanFullSpeed = fanFullSpeed_q;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    chk_summary_bit: assert property (
        ce && rdSr1 |=> regRdData[SR1_SUMMARY_BIT] == $past(|sr2_q))
        else $error("summary bit does not follow second status");
    chk_first_set: assert property (
        ce |=> (sr1_q & $past(sr1Src)) == $past(sr1Src))
        else $error("first status bit missed a source");
    chk_second_set: assert property (
        ce |=> (sr2_q & $past(sr2Src)) == $past(sr2Src))
        else $error("second status bit missed a source");
    chk_sticky_hold: assert property (
        ce && !rdSr2 |=> (sr2_q & $past(sr2_q)) == $past(sr2_q))
        else $error("status bit dropped without a read");
    chk_alert_drive: assert property (
        ce |=> alertSharedOe == $past(cfg3_q[CFG3_ALERT_BIT] && alertReq))
        else $error("shared alert drive wrong");
    chk_thermal_event_pin_gate: assert property (
        ce && !cfg3_q[CFG3_THERMAL_EVENT_PIN_EN_BIT] |-> !thermActive
            ##1 (fiveVoltInputSel && fanFullSpeed == 3'h0))
        else $error("thermal input active while disabled");
    chk_boost_fans: assert property (
        ce |=> fanFullSpeed == ($past({3{cfg3_q[CFG3_BOOST_BIT] && thermActive}})
                                & $past(fanRunning)))
        else $error("fan boost wrong");
    chk_timer_pause: assert property (
        ce && !thermActive && !rdTimer |=> $stable(tmr.value))
        else $error("timer moved while event idle");
    chk_timer_sat: assert property (
        ce && tmr.value == TIMER_FULL && !rdTimer |=> tmr.value == TIMER_FULL)
        else $error("timer left full scale");
    chk_timer_clear: assert property (
        ce && rdTimer && !thermActive |=> tmr.value == 8'h00)
        else $error("timer not cleared by read");
    chk_read_busy: assert property (
        ce && rdTimer && thermActive |=> tmr.value == 8'h01)
        else $error("timer not restarted at one");
    chk_timer_limit: assert property (
        ce && cfg3_q[CFG3_THERMAL_EVENT_PIN_EN_BIT] && timerOver |=> sr2_q[SR2_TIMER_BIT])
        else $error("timer limit flag not set");

    cov_alert_shared: cover property (ce && alertSharedOe_q);
    cov_timer_full: cover property (tmr.value == TIMER_FULL);
    cov_read_busy: cover property (ce && rdTimer && thermActive);

endmodule

//--- reg_host.sv
/*
 * Register host model: issues byte reads and writes on the block's
 * register strobes, one access at a time.
 * Assumes the block takes a strobe at a rising edge of clk and shows
 * read data in the following cycle.
 */
`timescale 1ns/1ps
module reg_host (
    // Clock
    input wire logic clk,
    // Register port
    output logic [7:0] regAddr,
    output logic regWr,
    output logic regRd,
    output logic [7:0] regWrData,
    input wire logic [7:0] regRdData
);
    initial begin
        regAddr = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        regWrData = 8'h00;
    end

    // Released lines show the inverse so stale values never pass for live ones
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regWrData = d;
        regWr = 1'b1;
        @(negedge clk);
        regWr = 1'b0;
        regAddr = ~a;
        regWrData = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regRd = 1'b1;
        @(negedge clk);
        regRd = 1'b0;
        regAddr = ~a;
        d = regRdData;
    endtask
endmodule

//--- status_alert_thermal_event_pin_timer_tb.sv
/*
 * Self-checking bench for the limit-status, alert and assertion-timer block.
 * Assumes the register host model and a shortened timer tick of 8 cycles.
 */
`timescale 1ns/1ps
module status_alert_thermal_event_pin_timer_tb;
    import alert_status_pkg::*;

    // ************************************************************
    // Signals and instances
    // ************************************************************
    logic clk, srst, ce, overtempEvent, vidChangeSel, thermMainN, thermMultiN;
    logic [4:0] volt;
    logic [2:0] temp, fanRun, fanFull;
    logic [1:0] diode;
    logic [3:0] fanSlow;
    logic [5:0] voltage_id_code;
    logic [7:0] regAddr, regWrData, regRdData, rdv;
    logic regWr, regRd, shOe, muOe, pinOut, fiveSel;
    int errTotal = 0;
    int checksDone = 0;
    logic [31:0] seed = 32'h6d20721a;

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    status_alert_thermal_event_pin_timer #(.TickCycles(8)) i_dut (
        .clk(clk), .srst(srst), .ce(ce), .voltOutOfLimit(volt), .tempOutOfLimit(temp),
        .diodeFault(diode), .fanSlow(fanSlow), .overtempEvent(overtempEvent),
        .vidChangeSel(vidChangeSel), .fanRunning(fanRun), .voltageIdCode(voltage_id_code),
        .thermalEventMainN(thermMainN), .thermalEventMultiN(thermMultiN),
        .regAddr(regAddr), .regWr(regWr), .regRd(regRd), .regWrData(regWrData),
        .regRdData(regRdData), .alertSharedOe(shOe), .alertMultiOe(muOe),
        .alertPinOut(pinOut), .fiveVoltInputSel(fiveSel), .fanFullSpeed(fanFull)
    );

    reg_host i_host (
        .clk(clk), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
        .regWrData(regWrData), .regRdData(regRdData)
    );

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [7:0] expS2();
        return {diode, fanSlow, overtempEvent, volt[4]};
    endfunction

    function automatic logic [7:0] expS1();
        return {|expS2(), temp, volt[3:0]};
    endfunction

    // 2.5 V has no mask bit, so it always reaches the alert
    function automatic logic expReq(input logic [7:0] m1, input logic [7:0] m2);
        logic [7:0] s1;
        logic [7:0] s2;
        s1 = expS1();
        s2 = expS2();
        return (|(s1[6:2] & ~m1[6:2])) | (s1[1] & ~m1[0]) | s1[0] | ((|(s2 & ~m2)) & ~m1[7]);
    endfunction

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checksDone++;
        if (seen !== exp) begin
            errTotal++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        i_host.rd(a, rdv);
        check($sformatf("register %h", a), rdv, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Holds one thermal pin low for k cycles; en says whether boost should follow
    task automatic pulse(input int k, input bit useMulti, input bit en);
        @(negedge clk);
        if (useMulti) thermMultiN = 1'b0;
        else thermMainN = 1'b0;
        cyc(k);
        check("fan boost", {5'h0, fanFull}, {5'h0, en ? fanRun : 3'h0});
        thermMainN = 1'b1;
        thermMultiN = 1'b1;
        cyc(4);
        check("fan boost off", {5'h0, fanFull}, 8'h00);
    endtask

    task automatic reportAndStop();
        if (errTotal == 0 && checksDone > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #2_000_000;
        errTotal++;
        reportAndStop();
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        logic [7:0] m1, m2, s1e, s2e;
        logic [1:0] role;
        logic req;
        ce = 1'b1;
        srst = 1'b1;
        {volt, temp, diode, fanSlow, overtempEvent} = 15'h0;
        {vidChangeSel, fanRun, voltage_id_code} = 10'h0;
        thermMainN = 1'b1;
        thermMultiN = 1'b1;
        cyc(4);
        srst = 1'b0;
        check("alert enables", {6'h0, shOe, muOe}, 8'h00);
        check("five volt select", {7'h0, fiveSel}, 8'h01);
        rdChk(ALERT_MASK_FIRST_ADDR, MASK_RESET);
        rdChk(ALERT_MASK_SECOND_ADDR, MASK_RESET);
        rdChk(ASSERTION_TIME_ADDR, 8'h00);
        rdChk(8'h10, 8'h00);
        i_host.wr(CONFIG_THIRD_ADDR, 8'h01);
        for (int i = 0; i < 40; i++) begin
            seed = lfsr(seed);
            if (i == 0) seed = 32'hffff_ffff;
            {role, m2, m1} = seed[17:0];
            i_host.wr(ALERT_MASK_FIRST_ADDR, m1);
            i_host.wr(ALERT_MASK_SECOND_ADDR, m2);
            i_host.wr(CONFIG_FOURTH_ADDR, {6'h0, role});
            seed = lfsr(seed);
            {fanRun, volt, temp, diode, fanSlow, overtempEvent} = seed[17:0];
            cyc(4);
            req = expReq(m1, m2);
            s1e = expS1();
            s2e = expS2();
            check("shared alert", {7'h0, shOe}, {7'h0, req});
            check("multi alert", {7'h0, muOe}, {7'h0, req & (role == 2'h1)});
            check("alert level", {7'h0, pinOut}, 8'h00);
            rdChk(ALERT_MASK_SECOND_ADDR, m2);
            {volt, temp, diode, fanSlow, overtempEvent} = 15'h0;
            cyc(3);
            check("held alert", {7'h0, shOe}, {7'h0, req});
            rdChk(LIMIT_STATUS_FIRST_ADDR, s1e);
            rdChk(LIMIT_STATUS_SECOND_ADDR, s2e);
            rdChk(LIMIT_STATUS_FIRST_ADDR, 8'h00);
            rdChk(LIMIT_STATUS_SECOND_ADDR, 8'h00);
            check("released alert", {7'h0, shOe}, 8'h00);
        end
        // Handler flow: mask a persisting fault, poll, unmask once it clears
        i_host.wr(ALERT_MASK_FIRST_ADDR, 8'h00);
        i_host.wr(ALERT_MASK_SECOND_ADDR, 8'h00);
        temp = 3'h2;
        cyc(4);
        check("fault alert", {7'h0, shOe}, 8'h01);
        rdChk(LIMIT_STATUS_FIRST_ADDR, 8'h20);
        i_host.wr(ALERT_MASK_FIRST_ADDR, 8'h20);
        cyc(2);
        check("masked alert", {7'h0, shOe}, 8'h00);
        rdChk(LIMIT_STATUS_FIRST_ADDR, 8'h20);
        temp = 3'h0;
        cyc(3);
        rdChk(LIMIT_STATUS_FIRST_ADDR, 8'h20);
        rdChk(LIMIT_STATUS_FIRST_ADDR, 8'h00);
        i_host.wr(ALERT_MASK_FIRST_ADDR, 8'h00);
        cyc(2);
        check("unmasked alert", {7'h0, shOe}, 8'h00);
        vidChangeSel = 1'b1;
        cyc(4);
        i_host.rd(LIMIT_STATUS_SECOND_ADDR, rdv);
        voltage_id_code = 6'h2a;
        cyc(6);
        rdChk(LIMIT_STATUS_SECOND_ADDR, 8'h01);
        rdChk(LIMIT_STATUS_SECOND_ADDR, 8'h00);
        vidChangeSel = 1'b0;
        // Timer runs 8 cycles a tick here
        fanRun = 3'h5;
        i_host.wr(CONFIG_THIRD_ADDR, 8'h06);
        i_host.wr(CONFIG_FOURTH_ADDR, 8'h02);
        check("five volt select", {7'h0, fiveSel}, 8'h00);
        pulse(3, 1'b0, 1'b1);
        rdChk(ASSERTION_TIME_ADDR, 8'h01);
        pulse(20, 1'b0, 1'b1);
        rdChk(ASSERTION_TIME_ADDR, 8'h02);
        pulse(20, 1'b0, 1'b1);
        cyc(30);
        pulse(14, 1'b0, 1'b1);
        rdChk(ASSERTION_TIME_ADDR, 8'h04);
        pulse(20, 1'b1, 1'b1);
        rdChk(ASSERTION_TIME_ADDR, 8'h02);
        i_host.wr(CONFIG_THIRD_ADDR, 8'h05);
        pulse(20, 1'b1, 1'b0);
        rdChk(ASSERTION_TIME_ADDR, 8'h00);
        i_host.wr(CONFIG_THIRD_ADDR, 8'h06);
        pulse(2100, 1'b0, 1'b1);
        rdChk(ASSERTION_TIME_ADDR, TIMER_FULL);
        rdChk(ASSERTION_TIME_ADDR, 8'h00);
        i_host.rd(LIMIT_STATUS_SECOND_ADDR, rdv);
        thermMainN = 1'b0;
        cyc(10);
        i_host.rd(ASSERTION_TIME_ADDR, rdv);
        rdChk(ASSERTION_TIME_ADDR, 8'h01);
        thermMainN = 1'b1;
        rdChk(LIMIT_STATUS_SECOND_ADDR, 8'h20);
        i_host.rd(ASSERTION_TIME_ADDR, rdv);
        i_host.rd(LIMIT_STATUS_SECOND_ADDR, rdv);
        i_host.wr(TIMER_LIMIT_ADDR, 8'h02);
        pulse(20, 1'b0, 1'b1);
        rdChk(LIMIT_STATUS_SECOND_ADDR, 8'h00);
        pulse(14, 1'b0, 1'b1);
        rdChk(LIMIT_STATUS_SECOND_ADDR, 8'h20);
        reportAndStop();
    end
endmodule
